// >>> hdl/ahbi_cfg.svh
// Constants for the converter host bus controller: addresses, counts and timing
`ifndef AHBI_CFG_SVH
`define AHBI_CFG_SVH

// ***************************************************************
// Clock and strobe timing
// ***************************************************************
`define AHBI_CLK_NS       20
`define AHBI_STROBE_NS    200
`define AHBI_STROBE_CYC   ((`AHBI_STROBE_NS + `AHBI_CLK_NS - 1) / `AHBI_CLK_NS)
`define AHBI_WAIT_NS      250
`define AHBI_WAIT_CYC     ((`AHBI_WAIT_NS + `AHBI_CLK_NS - 1) / `AHBI_CLK_NS)
`define AHBI_CNT_W        5

// ***************************************************************
// Address map of the converter as seen from the host
// ***************************************************************
`define AHBI_IO_PORT      8'hE0
`define AHBI_MEM_ADDR     16'h6000
`define AHBI_DUMMY_ADDR   16'h0000
`define AHBI_RESTART_VEC  16'h0038
`define AHBI_RAM_BASE     8'h20
`define AHBI_RAM_LAST     8'h2F
`define AHBI_LAST_IDX     4'hF

`endif

// >>> hdl/ahbi_pkg.sv
// Types shared by the converter host bus controller modules
package ahbi_pkg;

    // Host sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_START  = 6'h02,
        ST_WAIT   = 6'h04,
        ST_VECTOR = 6'h08,
        ST_READ   = 6'h10,
        ST_STORE  = 6'h20
    } ahbi_state_t;

    // Where the converter sits in the host's map
    typedef enum logic [1:0] {
        MAP_MEM    = 2'h0,
        MAP_IO     = 2'h1,
        MAP_DIRECT = 2'h2,
        MAP_MCU    = 2'h3
    } ahbi_map_t;

    typedef struct packed {
        ahbi_state_t state;
        logic [3:0]  ptr;
        logic        block;
        logic        init_done;
        logic        req;
        logic [7:0]  result;
        logic        result_valid;
        logic        block_done;
        logic        store_we;
        logic [7:0]  store_addr;
    } ahbi_host_st_t;

    typedef struct packed {
        logic                 on;
        logic                 ack;
        logic [4:0]           cnt;
    } ahbi_strobe_st_t;

endpackage : ahbi_pkg

// >>> hdl/ahbi_strobe_if.sv
// Handshake between the host sequencer and its strobe timer
interface ahbi_strobe_if;
    logic req;
    logic is_io;
    logic on;
    logic ack;

    modport gen  (input req, input is_io, output on, output ack);
    modport user (output req, output is_io, input on, input ack);
endinterface : ahbi_strobe_if

// >>> hdl/ahbi_strobe_gen.sv
// Strobe timer: times one read or write strobe, with an I/O wait state
`include "ahbi_cfg.svh"

module ahbi_strobe_gen (
    input  wire logic     i_clk_sys,
    input  wire logic     i_reset_n,
    input  wire logic     i_sep_request,
    ahbi_strobe_if.gen    strobe
);

    localparam logic [4:0] BASE_LEN = 5'(`AHBI_STROBE_CYC);
    localparam logic [4:0] WAIT_LEN = 5'(`AHBI_WAIT_CYC);

    ahbi_pkg::ahbi_strobe_st_t q;
    ahbi_pkg::ahbi_strobe_st_t d;

    // ***************************************************************
    // Strobe sequencing
    // ***************************************************************
    // Request level starts a strobe; ack marks its last cycle
    always_comb begin
        d     = q;
        d.ack = 1'b0;
        if (!q.on) begin
            if (strobe.req && !q.ack) begin
                d.on  = 1'b1;
                // Thirteen extra bus clocks of wait on I/O cycles of a separate-request host
                d.cnt = (strobe.is_io && i_sep_request) ? 5'(BASE_LEN + WAIT_LEN - 5'h01)
                                                         : 5'(BASE_LEN - 5'h01);
            end
        end else if (q.cnt == 5'h00) begin
            d.on  = 1'b0;
        end else begin
            d.cnt = 5'(q.cnt - 5'h01);
        end
        if (q.on && q.cnt == 5'h01) begin
            d.ack = 1'b1;
        end
        if (q.on && q.cnt == 5'h00 && BASE_LEN == 5'h01) begin
            d.ack = 1'b0;
        end
    end

    // State register
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Ack is high in the strobe's final cycle, while the strobe is still on
    assign strobe.on  = q.on;
    assign strobe.ack = q.ack;

endmodule : ahbi_strobe_gen

// >>> hdl/ahbi_host.sv
// Host-side bus controller that starts, waits for and reads the 8-bit converter
`include "ahbi_cfg.svh"

// Summary of operation
// - Memory-mapped: select decoded from memory address, memory strobes drive converter.
// - I/O-mapped: I/O strobes, select decoded from the low address byte only.
// - Standard select, read and write lines wire straight to the converter.
// - Converter is one 8-bit port E0; output starts, input fetches result.
// - On done, vector via 0038, read, store at pointer, bump pointer, restart.
// - With eight or fewer devices, one low address bit serves as select.
// - Single-chip controller drives select from bit 0 of its port 1.
// - Single-chip controller strobes come from accessing a dummy external address.
// - Sixteen results land in internal RAM locations 20 through 2F.
// - Separate request lines are gated with generic strobes into equivalent strobes.
// - I/O cycles of separate-request host stretch strobes by a 250 ns wait, 13 clocks.
// - During I/O input the upper address byte carries an output byte.
// - Free-running: select held low, shared write/done node pulsed once.
module ahbi_host (
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    input  wire logic [1:0]  i_map_mode,
    input  wire logic        i_sep_request,
    input  wire logic        i_freerun,
    input  wire logic [2:0]  i_direct_sel,
    input  wire logic [7:0]  i_mux_channel,
    input  wire logic        i_run,
    input  wire logic        i_single_start,
    input  wire logic        i_single_read,
    input  wire logic        i_conversion_done_n,
    input  wire logic [7:0]  i_data_bus,
    output logic      [7:0]  o_data_bus,
    output logic             o_data_bus_oe_n,
    output logic      [15:0] o_addr,
    output logic             o_conv_select_n,
    output logic             o_port1_bit0,
    output logic             o_read_strobe_n,
    output logic             o_write_strobe_n,
    output logic             o_memory_request_n,
    output logic             o_io_request_n,
    output logic             o_memory_read_strobe_n,
    output logic             o_memory_write_strobe_n,
    output logic             o_io_read_strobe_n,
    output logic             o_io_write_strobe_n,
    output logic             o_busy,
    output logic      [7:0]  o_result,
    output logic             o_result_valid,
    output logic             o_block_done,
    output logic             o_store_we,
    output logic      [7:0]  o_store_addr
);

    ahbi_pkg::ahbi_host_st_t q;
    ahbi_pkg::ahbi_host_st_t d;
    ahbi_strobe_if           strobe ();
    ahbi_pkg::ahbi_map_t     map;
    logic                    cycle_wr;
    logic                    cycle_rd;
    logic                    cycle_on;
    logic                    is_io;
    logic [7:0]              direct_n;

    assign map = ahbi_pkg::ahbi_map_t'(i_map_mode);

    // ***************************************************************
    // Strobe timer
    // ***************************************************************
    ahbi_strobe_gen u_strobe (
        .i_clk_sys     (i_clk_sys),
        .i_reset_n     (i_reset_n),
        .i_sep_request (i_sep_request),
        .strobe        (strobe)
    );

    assign strobe.req   = q.req;
    assign strobe.is_io = is_io;

    // ***************************************************************
    // Sequencer
    // ***************************************************************
    // One block takes sixteen results; single commands run one cycle each
    always_comb begin
        d              = q;
        d.result_valid = 1'b0;
        d.block_done   = 1'b0;
        d.store_we     = 1'b0;
        case (q.state)
            ahbi_pkg::ST_IDLE: begin
                if (i_freerun && !q.init_done) begin
                    // One start pulse after reset kicks the self-restarting loop
                    d.block = 1'b1;
                    d.ptr   = 4'h0;
                    d.req   = 1'b1;
                    d.state = ahbi_pkg::ST_START;
                end else if (i_run) begin
                    d.block = 1'b1;
                    d.ptr   = 4'h0;
                    d.req   = 1'b1;
                    d.state = ahbi_pkg::ST_START;
                end else if (i_single_start) begin
                    d.block = 1'b0;
                    d.req   = 1'b1;
                    d.state = ahbi_pkg::ST_START;
                end else if (i_single_read) begin
                    d.block = 1'b0;
                    d.req   = 1'b1;
                    d.state = ahbi_pkg::ST_READ;
                end
            end
            ahbi_pkg::ST_START: begin
                // Output cycle to the converter port starts a conversion
                if (strobe.ack) begin
                    d.req       = 1'b0;
                    d.init_done = 1'b1;
                    d.state     = q.block ? ahbi_pkg::ST_WAIT : ahbi_pkg::ST_IDLE;
                end
            end
            ahbi_pkg::ST_WAIT: begin
                // Done stays high on an abandoned conversion, so keep waiting
                if (!i_conversion_done_n) begin
                    d.state = ahbi_pkg::ST_VECTOR;
                end else if (i_single_start && !i_freerun) begin
                    // A new start mid-conversion restarts the converter
                    d.req   = 1'b1;
                    d.state = ahbi_pkg::ST_START;
                end
            end
            ahbi_pkg::ST_VECTOR: begin
                // Restart-vector fetch slot before the handler's read
                d.req   = 1'b1;
                d.state = ahbi_pkg::ST_READ;
            end
            ahbi_pkg::ST_READ: begin
                // Sampled in the strobe's last cycle, data is settled by then
                if (strobe.ack) begin
                    d.req          = 1'b0;
                    d.result       = i_data_bus;
                    d.result_valid = 1'b1;
                    d.state        = q.block ? ahbi_pkg::ST_STORE : ahbi_pkg::ST_IDLE;
                end
            end
            ahbi_pkg::ST_STORE: begin
                // Store at pointer, bump it, then restart the converter, unless the store at index F ends the block
                d.store_we   = 1'b1;
                d.store_addr = 8'(`AHBI_RAM_BASE + {4'h0, q.ptr});
                d.ptr        = 4'(q.ptr + 4'h1);
                if (i_freerun) begin
                    // Converter restarts itself through the tied node
                    d.state = ahbi_pkg::ST_WAIT;
                end else if (q.ptr == `AHBI_LAST_IDX) begin
                    d.block      = 1'b0;
                    d.block_done = 1'b1;
                    d.state      = ahbi_pkg::ST_IDLE;
                end else begin
                    d.req   = 1'b1;
                    d.state = ahbi_pkg::ST_START;
                end
            end
            default: begin
                d = '0;
                d.state = ahbi_pkg::ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            q            <= '0;
            q.state      <= ahbi_pkg::ST_IDLE;
            q.store_addr <= `AHBI_RAM_BASE;
        end else begin
            q <= d;
        end
    end

    // ***************************************************************
    // Address and select decode
    // ***************************************************************
    assign cycle_wr = (q.state == ahbi_pkg::ST_START);
    assign cycle_rd = (q.state == ahbi_pkg::ST_READ);
    assign cycle_on = cycle_wr | cycle_rd;
    assign is_io    = (map == ahbi_pkg::MAP_IO) || (map == ahbi_pkg::MAP_DIRECT);

    // One low address bit per device, low for the chosen one
    for (genvar k = 0; k < 8; k++) begin : g_direct
        assign direct_n[k] = (i_direct_sel != 3'(k));
    end

    // Address presented for each access kind
    always_comb begin
        o_addr = `AHBI_DUMMY_ADDR;
        if (q.state == ahbi_pkg::ST_VECTOR) begin
            o_addr = `AHBI_RESTART_VEC;
        end else if (cycle_on) begin
            case (map)
                ahbi_pkg::MAP_MEM:    o_addr = `AHBI_MEM_ADDR;
                // Upper byte repeats the port, or carries the mux byte on input
                ahbi_pkg::MAP_IO:     o_addr = {(cycle_rd ? i_mux_channel : `AHBI_IO_PORT),
                                                `AHBI_IO_PORT};
                ahbi_pkg::MAP_DIRECT: o_addr = {8'h00, direct_n};
                ahbi_pkg::MAP_MCU:    o_addr = `AHBI_DUMMY_ADDR;
                default:              o_addr = `AHBI_DUMMY_ADDR;
            endcase
        end
    end

    // Select from decode; free-running holds it low throughout
    always_comb begin
        o_conv_select_n = 1'b1;
        if (i_freerun) begin
            o_conv_select_n = 1'b0;
        end else if (cycle_on) begin
            case (map)
                ahbi_pkg::MAP_MEM:    o_conv_select_n = (o_addr != `AHBI_MEM_ADDR);
                ahbi_pkg::MAP_IO:     o_conv_select_n = (o_addr[7:0] != `AHBI_IO_PORT);
                ahbi_pkg::MAP_DIRECT: o_conv_select_n = o_addr[i_direct_sel];
                default:              o_conv_select_n = 1'b1;
            endcase
        end
    end

    // No decoder in single-chip mode: a port pin is the select
    assign o_port1_bit0 = !(i_freerun || (cycle_on && map == ahbi_pkg::MAP_MCU));

    // ***************************************************************
    // Strobes
    // ***************************************************************
    // Plain select/read/write lines go straight to the converter
    assign o_read_strobe_n    = !(strobe.on && cycle_rd);
    assign o_write_strobe_n   = !(strobe.on && cycle_wr);
    assign o_memory_request_n = !(cycle_on && !is_io);
    assign o_io_request_n     = !(cycle_on && is_io);

    // Request lines gated with generic strobes form equivalent strobes
    assign o_memory_read_strobe_n  = o_read_strobe_n | o_memory_request_n;
    assign o_memory_write_strobe_n = o_write_strobe_n | o_memory_request_n;
    assign o_io_read_strobe_n      = o_read_strobe_n | o_io_request_n;
    assign o_io_write_strobe_n     = o_write_strobe_n | o_io_request_n;

    // Host drives the bus only on its own write; converter ignores the byte
    assign o_data_bus      = q.result;
    assign o_data_bus_oe_n = o_write_strobe_n;

    // ***************************************************************
    // User side
    // ***************************************************************
    assign o_busy         = (q.state != ahbi_pkg::ST_IDLE);
    assign o_result       = q.result;
    assign o_result_valid = q.result_valid;
    assign o_block_done   = q.block_done;
    assign o_store_we     = q.store_we;
    assign o_store_addr   = q.store_addr;

endmodule : ahbi_host

// >>> verification/ahbi_host_checker.sv
// Timing and gating assertions for the converter host bus controller
module ahbi_host_checker (
    input wire logic        i_clk_sys,
    input wire logic        i_reset_n,
    input wire logic [1:0]  i_map_mode,
    input wire logic [7:0]  i_mux_channel,
    input wire logic [15:0] o_addr,
    input wire logic        o_data_bus_oe_n,
    input wire logic        o_conv_select_n,
    input wire logic        o_read_strobe_n,
    input wire logic        o_write_strobe_n,
    input wire logic        o_memory_request_n,
    input wire logic        o_io_request_n,
    input wire logic        o_memory_read_strobe_n,
    input wire logic        o_io_read_strobe_n,
    input wire logic        o_io_write_strobe_n,
    input wire logic        o_result_valid,
    input wire logic        o_store_we,
    input wire logic [7:0]  o_store_addr,
    input wire logic        o_busy,
    input wire logic [7:0]  o_data_bus
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    // ****************************************
    // Strobe shape and address checks
    // ****************************************
    // A memory-side strobe holds for ten cycles, no wait state
    sequence s_rd_ten;
        (!o_read_strobe_n)[*8] ##1 !o_read_strobe_n ##1 !o_read_strobe_n;
    endsequence
    a_mem_strobe_width:
    assert property ($fell(o_read_strobe_n) && !o_memory_request_n |-> s_rd_ten ##1 o_read_strobe_n)
        else $error("memory read strobe width wrong");
    a_oe_tracks_write:
    assert property (!o_data_bus_oe_n |-> o_read_strobe_n && !o_write_strobe_n)
        else $error("bus driven outside a write strobe");
    a_busy_on_strobe:
    assert property (!o_read_strobe_n || !o_write_strobe_n |-> o_busy)
        else $error("strobe low while sequencer idle");
    a_bus_steady_drive:
    assert property (!o_data_bus_oe_n && !$rose(o_write_strobe_n) |-> $stable(o_data_bus))
        else $error("driven bus byte changed mid-strobe");
    a_mem_rd_gating:
    assert property (o_memory_read_strobe_n == (o_read_strobe_n | o_memory_request_n))
        else $error("memory read strobe not gated by request");
    a_io_wr_gating:
    assert property (o_io_write_strobe_n == (o_write_strobe_n | o_io_request_n))
        else $error("io write strobe not gated by request");
    a_sel_covers_rd:
    assert property (!o_memory_read_strobe_n && i_map_mode == 2'h0 |-> !o_conv_select_n)
        else $error("select high during memory read");
    a_io_port_addr:
    assert property (!o_io_write_strobe_n && i_map_mode == 2'h1 |-> o_addr == 16'hE0E0)
        else $error("io write not at port address");
    a_mux_on_input:
    assert property (!o_io_read_strobe_n && i_map_mode == 2'h1 |-> o_addr == {i_mux_channel, 8'hE0})
        else $error("channel byte missing on io read");
    a_valid_after_rd:
    assert property ($rose(o_read_strobe_n) |-> o_result_valid)
        else $error("no result pulse after read");
    a_store_in_window:
    assert property (o_store_we |-> o_store_addr >= 8'h20 && o_store_addr <= 8'h2F)
        else $error("store outside 20 to 2F");
endmodule : ahbi_host_checker

bind ahbi_host ahbi_host_checker i_ahbi_host_checker (.i_clk_sys, .i_reset_n, .i_map_mode,
    .i_mux_channel, .o_addr, .o_data_bus_oe_n, .o_conv_select_n, .o_read_strobe_n,
    .o_write_strobe_n, .o_memory_request_n, .o_io_request_n, .o_memory_read_strobe_n,
    .o_io_read_strobe_n, .o_io_write_strobe_n, .o_result_valid, .o_store_we, .o_store_addr,
    .o_busy, .o_data_bus);

// >>> verification/ahbi_adc_model.sv
// Behavioural model of the 8-bit converter seen from its bus pins
module ahbi_adc_model #(
    parameter int CONV_CYC = 30
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_select_n,
    input  wire logic       i_read_n,
    input  wire logic       i_write_n,
    output logic            o_done_n,
    output logic      [7:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] latch_q;
    logic [7:0] last_q;
    logic       wr_q;
    int         cnt;

    initial begin
        o_done_n = 1'b1;
        latch_q  = 8'h00;
        last_q   = 8'h00;
        wr_q     = 1'b1;
        cnt      = 0;
    end

    // Start on release of select and write; a restart drops the running one
    always @(posedge i_clk_sys) begin
        wr_q <= i_write_n | i_select_n;
        if (!wr_q && (i_write_n | i_select_n)) begin
            cnt      <= CONV_CYC;
            o_done_n <= 1'b1;
        end else if (cnt == 1) begin
            latch_q  <= latch_q + 8'h11;
            o_done_n <= 1'b0;
            cnt      <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
        if (!i_select_n && !i_read_n) begin
            o_done_n <= 1'b1;
            last_q   <= latch_q;
        end
    end

    // Released bus shows the inverse, so a stale byte never looks valid
    assign o_data = (!i_select_n && !i_read_n) ? latch_q : ~last_q;
endmodule : ahbi_adc_model

// >>> verification/ahbi_host_bench.sv
// Self-checking testbench for the converter host bus controller
module ahbi_host_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys, i_reset_n, i_sep_request, i_freerun, i_run, i_single_start, i_single_read;
    logic i_conversion_done_n, o_conv_select_n, o_port1_bit0, o_read_strobe_n, o_write_strobe_n;
    logic o_memory_request_n, o_io_request_n, o_memory_read_strobe_n, o_memory_write_strobe_n;
    logic o_io_read_strobe_n, o_io_write_strobe_n, o_result_valid, o_store_we, o_block_done;
    logic o_data_bus_oe_n, adc_sel_n, adc_rd_n, adc_wr_n;
    logic [1:0]  i_map_mode;
    logic [2:0]  i_direct_sel;
    logic [7:0]  i_mux_channel, i_data_bus, o_result, o_store_addr, n;
    logic [15:0] o_addr;
    logic [15:0] addr_tab [4] = '{16'h6000, 16'h3CE0, 16'h00DF, 16'h0000};
    int          failures, cmp_count, bd;

    ahbi_host i_ahbi_host (.i_clk_sys, .i_reset_n, .i_map_mode, .i_sep_request, .i_freerun,
        .i_direct_sel, .i_mux_channel, .i_run, .i_single_start, .i_single_read,
        .i_conversion_done_n, .i_data_bus, .o_data_bus(), .o_data_bus_oe_n, .o_addr,
        .o_conv_select_n, .o_port1_bit0, .o_read_strobe_n, .o_write_strobe_n,
        .o_memory_request_n, .o_io_request_n, .o_memory_read_strobe_n, .o_memory_write_strobe_n,
        .o_io_read_strobe_n, .o_io_write_strobe_n, .o_busy(), .o_result, .o_result_valid,
        .o_block_done, .o_store_we, .o_store_addr);
    ahbi_adc_model i_ahbi_adc_model (.i_clk_sys, .i_select_n(adc_sel_n), .i_read_n(adc_rd_n),
        .i_write_n(adc_wr_n), .o_done_n(i_conversion_done_n), .o_data(i_data_bus));

    // ****************************************
    // Wiring of the converter per map mode
    // ****************************************
    always_comb begin
        case (i_map_mode)
            2'h0: {adc_sel_n, adc_rd_n, adc_wr_n} = {o_conv_select_n, o_memory_read_strobe_n,
                                                     o_memory_write_strobe_n};
            2'h1: {adc_sel_n, adc_rd_n, adc_wr_n} = {o_conv_select_n, o_io_read_strobe_n,
                                                     o_io_write_strobe_n};
            2'h2: {adc_sel_n, adc_rd_n, adc_wr_n} = {o_addr[i_direct_sel], o_io_read_strobe_n,
                                                     o_io_write_strobe_n};
            default: {adc_sel_n, adc_rd_n, adc_wr_n} = {o_port1_bit0, o_read_strobe_n,
                                                        o_write_strobe_n};
        endcase
        // Free-running ties write to done; the host's start pulls the node low
        if (i_freerun) adc_wr_n = o_write_strobe_n & i_conversion_done_n;
    end

    // Clock and watchdog; the span is well above the whole test sequence
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        repeat (8000) @(posedge i_clk_sys);
        failures++;
        close_out();
    end
    always @(negedge i_clk_sys) if (o_block_done === 1'b1) bd++;

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Pulse one of {run, start, read} for one cycle
    task automatic cmd(input logic [2:0] c);
        @(posedge i_clk_sys);
        {i_run, i_single_start, i_single_read} <= c;
        @(posedge i_clk_sys);
        {i_run, i_single_start, i_single_read} <= 3'h0;
    endtask : cmd

    // Start, wait for done, read; measure strobe, select and address
    task automatic t_single(input logic [1:0] m, input logic sep);
        int w;
        logic [15:0] a;
        logic s;
        @(posedge i_clk_sys);
        i_map_mode    <= m;
        i_sep_request <= sep;
        cmd(3'h2);
        for (int k = 0; k < 200 && i_conversion_done_n !== 1'b0; k++) @(negedge i_clk_sys);
        n = n + 8'h11;
        cmd(3'h1);
        w = 0;
        for (int k = 0; k < 60 && o_result_valid !== 1'b1; k++) begin
            @(negedge i_clk_sys);
            if (adc_rd_n === 1'b0) begin
                w++;
                a = o_addr;
                s = adc_sel_n;
            end
        end
        chk("strobe width", 16'(w), (sep && (m == 2'h1 || m == 2'h2)) ? 16'd23 : 16'd10);
        chk("select", {15'h0, s}, 16'h0000);
        chk("address", a, addr_tab[m]);
        chk("result", {8'h00, o_result}, {8'h00, n});
        @(negedge i_clk_sys);
        chk("done released", {15'h0, i_conversion_done_n}, 16'h0001);
    endtask : t_single

    // A block of sixteen results stored at 20 through 2F
    task automatic t_block;
        int w;
        @(posedge i_clk_sys);
        i_map_mode <= 2'h1;
        bd = 0;
        cmd(3'h4);
        for (int i = 0; i < 16; i++) begin
            for (int k = 0; k < 300 && o_store_we !== 1'b1; k++) @(negedge i_clk_sys);
            n = n + 8'h11;
            chk("store address", {8'h00, o_store_addr}, 16'h0020 + 16'(i));
            chk("stored byte", {8'h00, o_result}, {8'h00, n});
            @(negedge i_clk_sys);
            if (i == 3) begin
                // Restart mid-wait, before done: the abandoned result must not count
                repeat (24) @(negedge i_clk_sys);
                cmd(3'h2);
                w = 0;
                for (int k = 0; k < 30; k++) begin
                    @(negedge i_clk_sys);
                    if (adc_wr_n === 1'b0) w++;
                end
                chk("restart strobe", 16'(w), 16'd23);
            end
        end
        repeat (4) @(negedge i_clk_sys);
        chk("block done pulses", 16'(bd), 16'h0001);
    endtask : t_block

    // Free-running: a mid-run reset arms the one start pulse, then two results
    task automatic t_freerun;
        @(posedge i_clk_sys);
        i_reset_n  <= 1'b0;
        i_freerun  <= 1'b1;
        i_map_mode <= 2'h0;
        repeat (2) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            for (int k = 0; k < 300 && o_store_we !== 1'b1; k++) @(negedge i_clk_sys);
            n = n + 8'h11;
            chk("freerun byte", {8'h00, o_result}, {8'h00, n});
            chk("freerun address", {8'h00, o_store_addr}, 16'h0020 + 16'(i));
            chk("freerun select", {15'h0, o_conv_select_n}, 16'h0000);
            @(negedge i_clk_sys);
        end
        // Leave the loop through reset, as nothing else ends it
        @(posedge i_clk_sys);
        i_reset_n <= 1'b0;
        i_freerun <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
    endtask : t_freerun

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {i_run, i_single_start, i_single_read, i_sep_request, i_freerun} = 5'h00;
        {i_map_mode, i_direct_sel, i_mux_channel, i_reset_n} = {2'h0, 3'h5, 8'h3C, 1'b0};
        {failures, cmp_count, bd, n} = '0;
        repeat (15) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chk("reset store address", {8'h00, o_store_addr}, 16'h0020);
        @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        for (int m = 0; m < 4; m++) t_single(2'(m), 1'b0);
        t_single(2'h1, 1'b1);
        t_single(2'h2, 1'b1);
        t_block();
        t_freerun();
        close_out();
    end
endmodule : ahbi_host_bench
